// file: logic/spm_pkg.sv
package spm_pkg;
  localparam int NPIN = 8;
  localparam int CTRL_W = 24;
  localparam int STS_W = 10;
  localparam int SEL_W = 4;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_LEVEL = 10'h147;
  localparam logic [9:0] IDX_DIR = 10'h14b;
  localparam logic [9:0] IDX_CTRL = 10'h150;
  localparam logic [9:0] IDX_STS = 10'h151;
  localparam logic [9:0] IDX_MASK = 10'h152;
  localparam logic [11:0] ADDR_LEVEL = {IDX_LEVEL, 2'b00};
  localparam logic [11:0] ADDR_DIR = {IDX_DIR, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STS = {IDX_STS, 2'b00};
  localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};
  // control fields
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_ING_EN = 8;
  localparam int CTL_ING_EXT = 9;
  localparam int CTL_EGR_EN = 10;
  localparam int CTL_EGR_EXT = 11;
  localparam int CTL_ING_SEL_LSB = 16;
  localparam int CTL_EGR_SEL_LSB = 20;
  // status fields: [7:0] loss rise per pin, then insert samples
  localparam int STS_ING_INS = 8;
  localparam int STS_EGR_INS = 9;
  localparam logic [NPIN-1:0] LEVEL_RST = 8'h00;
  localparam logic [NPIN-1:0] DIR_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 24'h000000;
  localparam logic [STS_W-1:0] MASK_RST = 10'h000;
  // side 0 is ingress, side 1 is egress
  localparam int CLK_PIN [2] = '{1, 0};
  localparam int POS_PIN [2] = '{2, 5};
  localparam int NEG_PIN [2] = '{4, 3};
  // generated port clock: half period in ns, then in clk cycles
  localparam int CLK_NS = 5;
  localparam int LINK_HALF_NS = 60;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS / CLK_NS < 1) ? 1 :
    LINK_HALF_NS / CLK_NS;
endpackage : spm_pkg

// file: logic/spm_pin_mux.sv
// Summary of operation
// R1 - framer channel off and port off: pin is software general-purpose io
// R2 - each pin's direction comes from its own bit of the direction register
// R3 - input pin: reading its data bit returns the present pin level
// R4 - output pin: driven to the value last written to its data bit
// R5 - framer channel on, port off: pin is that channel's loss input
// R6 - high level on a loss input makes the channel declare loss
// R7 - ingress port clock wins: input when inserting, output when extracting
// R8 - insert mode replaces the selected stream with the dual-rail pin data
// R9 - ingress insert latches both rails on the port clock falling edge
// R10 - extract mode presents the selected stream on the dual-rail outputs
// R11 - ingress extract drives the clock, rails change on its rising edge
// R12 - egress insert samples both rails on the egress clock falling edge
// R13 - egress extract drives both rails, updated on its clock rising edge
// R14 - after reset every general-purpose pin is an input
module spm_pin_mux
  #(parameter int HALF_CYC = spm_pkg::LINK_HALF_CYC)
  (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [spm_pkg::NPIN-1:0] pin_i,
  output logic [spm_pkg::NPIN-1:0] pin_o,
  output logic [spm_pkg::NPIN-1:0] pin_oe,
  output logic [spm_pkg::NPIN-1:0] chan_loss,
  output logic [spm_pkg::SEL_W-1:0] ing_sel,
  output logic ing_ins_pos,
  output logic ing_ins_neg,
  output logic ing_ins_vld,
  input wire logic ing_ext_pos,
  input wire logic ing_ext_neg,
  output logic ing_ext_take,
  output logic [spm_pkg::SEL_W-1:0] egr_sel,
  output logic egr_ins_pos,
  output logic egr_ins_neg,
  output logic egr_ins_vld,
  input wire logic egr_ext_pos,
  input wire logic egr_ext_neg,
  output logic egr_ext_take,
  output logic irq
  );
  import spm_pkg::*;

  // places clock, positive and negative rail values on a side's pins
  function automatic logic [NPIN-1:0] spm_place(input int s,
    input logic c, input logic p, input logic n);
    logic [NPIN-1:0] v;
    v = '0;
    v[CLK_PIN[s]] = c;
    v[POS_PIN[s]] = p;
    v[NEG_PIN[s]] = n;
    return v;
  endfunction : spm_place

  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [NPIN-1:0] level_ff, dir_ff, pin_o_ff, pin_oe_ff, los_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [STS_W-1:0] sts_ff, mask_ff;
  logic [11:0] addr_ff;
  logic wr_ff, rd_ff, hrdy_ff, irq_ff;
  logic [31:0] hrdata_ff;
  logic [1:0] clk_prev_ff, lclk_ff, ins_pos_ff, ins_neg_ff, ins_vld_ff;
  logic [1:0] rail_pos_ff, rail_neg_ff, take_ff;

  // a pin change counts once the second and third stages agree
  wire [NPIN-1:0] agree = ~(s2_ff ^ s3_ff);
  wire [NPIN-1:0] nxt_lvl = (s2_ff & agree) | (lvl_ff & ~agree);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end
    else if (ce)
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  wire [NPIN-1:0] chan_en = ctrl_ff[CTL_CHAN_LSB +: NPIN];
  wire [1:0] port_en = {ctrl_ff[CTL_EGR_EN], ctrl_ff[CTL_ING_EN]};
  wire [1:0] port_ext = {ctrl_ff[CTL_EGR_EXT], ctrl_ff[CTL_ING_EXT]};
  wire [NPIN-1:0] ing_pins = spm_place(0, 1'b1, 1'b1, 1'b1);
  wire [NPIN-1:0] egr_pins = spm_place(1, 1'b1, 1'b1, 1'b1);
  // an enabled port takes its pins ahead of loss input and io
  wire [NPIN-1:0] port_fn = (port_en[0] ? ing_pins : '0) | // R7
    (port_en[1] ? egr_pins : '0);
  wire [NPIN-1:0] los_fn = chan_en & ~port_fn; // R5
  wire [NPIN-1:0] gpio_fn = ~chan_en & ~port_fn; // R1
  wire [NPIN-1:0] port_oe_v = (port_en[0] && port_ext[0] ? ing_pins : '0) |
    (port_en[1] && port_ext[1] ? egr_pins : '0); // R7
  wire [1:0] ext_pos_w = {egr_ext_pos, ing_ext_pos};
  wire [1:0] ext_neg_w = {egr_ext_neg, ing_ext_neg};
  wire [NPIN-1:0] side_val [2];

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_side
      logic [7:0] cnt_ff;
      wire clk_lvl = lvl_ff[CLK_PIN[s]];
      wire ins_on = port_en[s] & ~port_ext[s];
      wire ext_on = port_en[s] & port_ext[s];
      wire fall = ins_on & clk_prev_ff[s] & ~clk_lvl;
      wire tick = ext_on & (cnt_ff == 8'(HALF_CYC - 1));
      wire rise = tick & ~lclk_ff[s];
      assign side_val[s] = spm_place(s, lclk_ff[s], rail_pos_ff[s],
        rail_neg_ff[s]);
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          clk_prev_ff[s] <= 1'b0;
          ins_pos_ff[s] <= 1'b0;
          ins_neg_ff[s] <= 1'b0;
          ins_vld_ff[s] <= 1'b0;
        end
        else if (ce)
        begin
          clk_prev_ff[s] <= clk_lvl;
          ins_vld_ff[s] <= fall; // R8
          if (fall)
          begin
            // both rails taken together at the falling edge
            ins_pos_ff[s] <= lvl_ff[POS_PIN[s]]; // R9 R12
            ins_neg_ff[s] <= lvl_ff[NEG_PIN[s]]; // R9 R12
          end
        end
      end
      // generated clock stops low whenever extract is off
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          cnt_ff <= 8'h00;
          lclk_ff[s] <= 1'b0;
          rail_pos_ff[s] <= 1'b0;
          rail_neg_ff[s] <= 1'b0;
          take_ff[s] <= 1'b0;
        end
        else if (ce)
        begin
          cnt_ff <= (!ext_on || tick) ? 8'h00 : cnt_ff + 8'h01;
          lclk_ff[s] <= ext_on & (lclk_ff[s] ^ tick); // R11 R13
          take_ff[s] <= rise; // R10
          if (rise)
          begin
            rail_pos_ff[s] <= ext_pos_w[s]; // R11 R13
            rail_neg_ff[s] <= ext_neg_w[s]; // R11 R13
          end
        end
      end
    end
  endgenerate

  wire [NPIN-1:0] port_val = (side_val[0] & ing_pins & {NPIN{port_en[0]}}) |
    (side_val[1] & egr_pins & {NPIN{port_en[1]}});
  wire [NPIN-1:0] nxt_pin_o = (gpio_fn & level_ff) | (port_fn & port_val);
  wire [NPIN-1:0] nxt_pin_oe = (gpio_fn & dir_ff) | // R2
    (port_fn & port_oe_v);
  wire [NPIN-1:0] nxt_los = los_fn & lvl_ff; // R6
  wire [STS_W-1:0] evt = {ins_vld_ff[1], ins_vld_ff[0], nxt_los & ~los_ff};

  // bus: writes complete with no wait, reads take one wait state so
  // that a read right behind a write sees the written value
  wire acc = hsel & htrans[1] & hready;
  wire we_level = wr_ff && addr_ff == ADDR_LEVEL;
  wire we_dir = wr_ff && addr_ff == ADDR_DIR;
  wire we_ctrl = wr_ff && addr_ff == ADDR_CTRL;
  wire we_sts = wr_ff && addr_ff == ADDR_STS;
  wire we_mask = wr_ff && addr_ff == ADDR_MASK;
  wire [STS_W-1:0] sts_clr = we_sts ? hwdata[STS_W-1:0] : '0;
  // a new event beats a clear in the same cycle
  wire [STS_W-1:0] nxt_sts = (sts_ff & ~sts_clr) | evt;
  wire [NPIN-1:0] level_rd = (lvl_ff & ~dir_ff) | (level_ff & dir_ff); // R3
  wire [31:0] rd_mux =
    (addr_ff == ADDR_LEVEL) ? {24'h000000, level_rd} :
    (addr_ff == ADDR_DIR) ? {24'h000000, dir_ff} :
    (addr_ff == ADDR_CTRL) ? {8'h00, ctrl_ff} :
    (addr_ff == ADDR_STS) ? {22'h0, sts_ff} :
    (addr_ff == ADDR_MASK) ? {22'h0, mask_ff} : 32'h00000000;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      addr_ff <= 12'h000;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      hrdy_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
    end
    else if (ce)
    begin
      wr_ff <= acc & hwrite;
      rd_ff <= acc & ~hwrite;
      hrdy_ff <= ~(acc & ~hwrite);
      if (acc)
        addr_ff <= haddr[11:0];
      if (rd_ff)
        hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      level_ff <= LEVEL_RST;
      dir_ff <= DIR_RST; // R14
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      sts_ff <= '0;
      irq_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (we_level)
        level_ff <= hwdata[NPIN-1:0]; // R4
      if (we_dir)
        dir_ff <= hwdata[NPIN-1:0]; // R2
      if (we_ctrl)
        ctrl_ff <= hwdata[CTRL_W-1:0];
      if (we_mask)
        mask_ff <= hwdata[STS_W-1:0];
      sts_ff <= nxt_sts;
      irq_ff <= |(nxt_sts & mask_ff);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_o_ff <= '0;
      pin_oe_ff <= '0; // R14
      los_ff <= '0;
    end
    else if (ce)
    begin
      pin_o_ff <= nxt_pin_o; // R4
      pin_oe_ff <= nxt_pin_oe;
      los_ff <= nxt_los; // R6
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hrdy_ff;
  assign hresp = 1'b0;
  assign pin_o = pin_o_ff;
  assign pin_oe = pin_oe_ff;
  assign chan_loss = los_ff;
  assign ing_sel = ctrl_ff[CTL_ING_SEL_LSB +: SEL_W]; // R8 R10
  assign egr_sel = ctrl_ff[CTL_EGR_SEL_LSB +: SEL_W];
  assign ing_ins_pos = ins_pos_ff[0];
  assign ing_ins_neg = ins_neg_ff[0];
  assign ing_ins_vld = ins_vld_ff[0];
  assign ing_ext_take = take_ff[0];
  assign egr_ins_pos = ins_pos_ff[1];
  assign egr_ins_neg = ins_neg_ff[1];
  assign egr_ins_vld = ins_vld_ff[1];
  assign egr_ext_take = take_ff[1];
  assign irq = irq_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  wire ing_fall = g_side[0].fall;
  wire egr_fall = g_side[1].fall;

  a_gpio_dir_oe: assert property (ce |=> // R2
    ((pin_oe_ff & $past(gpio_fn)) == $past(gpio_fn & dir_ff)))
    else $error("io pin enable does not follow direction bit");
  a_gpio_out_val: assert property (ce |=> // R4
    ((pin_o_ff & $past(gpio_fn)) == $past(gpio_fn & level_ff)))
    else $error("io output pin does not carry written value");
  a_gpio_read_lvl: assert property ( // R3
    (ce && rd_ff && addr_ff == ADDR_LEVEL) |=>
    ((hrdata_ff[NPIN-1:0] & ~$past(dir_ff)) == $past(lvl_ff & ~dir_ff)))
    else $error("input pin read does not return pin level");
  a_gpio_only_idle: assert property (ce |=> // R1
    ((pin_oe_ff & $past(~gpio_fn & ~port_fn)) == '0))
    else $error("pin driven while in no driving function");
  a_loss_follow: assert property (ce |=> // R6
    (los_ff == $past(los_fn & lvl_ff)))
    else $error("loss output does not follow loss input pin");
  a_loss_not_driven: assert property (ce |=> // R5
    ((pin_oe_ff & $past(los_fn)) == '0))
    else $error("loss input pin is being driven");
  a_ing_clk_dir: assert property ((ce && port_en[0]) |=> // R7
    (pin_oe_ff[CLK_PIN[0]] == $past(port_ext[0])))
    else $error("ingress clock pin direction wrong for mode");
  a_ing_ins_capt: assert property ((ce && ing_fall) |=> // R9
    (ing_ins_vld && ing_ins_pos == $past(lvl_ff[POS_PIN[0]]) &&
    ing_ins_neg == $past(lvl_ff[NEG_PIN[0]])))
    else $error("ingress rails not latched at clock fall");
  a_egr_ins_capt: assert property ((ce && egr_fall) |=> // R12
    (egr_ins_vld && egr_ins_pos == $past(lvl_ff[POS_PIN[1]]) &&
    egr_ins_neg == $past(lvl_ff[NEG_PIN[1]])))
    else $error("egress rails not latched at clock fall");
  a_ing_ext_rise: assert property ( // R11
    (ce && ing_ext_take && port_ext[0] && port_en[0]) |=>
    (pin_o_ff[CLK_PIN[0]] &&
    pin_o_ff[POS_PIN[0]] == $past(ing_ext_pos, 2) &&
    pin_o_ff[NEG_PIN[0]] == $past(ing_ext_neg, 2)))
    else $error("ingress rails not updated with clock rise");
  a_ins_pins_in: assert property ( // R8
    (ce && port_en[0] && !port_ext[0]) |=>
    ((pin_oe_ff & ing_pins) == '0))
    else $error("ingress insert pins are being driven");
  a_ext_rails_out: assert property ( // R10
    (ce && port_en[1] && port_ext[1]) |=>
    (pin_oe_ff[POS_PIN[1]] && pin_oe_ff[NEG_PIN[1]]))
    else $error("egress extract rails are not driven");
  a_egr_ext_rise: assert property ((ce && egr_ext_take && port_en[1] &&
    port_ext[1] && $past(ce)) |-> ##1 (pin_o_ff[CLK_PIN[1]] && // R13
    pin_o_ff[NEG_PIN[1]] == $past(egr_ext_neg, 2)))
    else $error("egress rails not updated with clock rise");
  a_rst_input: assert property ($rose(rst_b) |-> // R14
    (dir_ff == '0 && pin_oe_ff == '0))
    else $error("pins not inputs after reset");

  c_ing_insert: cover property (ing_ins_vld ##[1:40] ing_ins_vld);
  c_egr_extract: cover property (egr_ext_take ##[1:40] egr_ext_take);
  c_irq_rise: cover property ($rose(irq));
  c_gpio_drive: cover property (|(pin_oe_ff & gpio_fn));
  c_loss_rise: cover property (|(los_fn & lvl_ff & ~los_ff));
endmodule : spm_pin_mux

// file: tb/spm_link_far.sv
// far-side line chip or test set on the shared pins
module spm_link_far
  (
  input wire logic [spm_pkg::NPIN-1:0] pin_o,
  input wire logic [spm_pkg::NPIN-1:0] pin_oe,
  input wire logic [spm_pkg::NPIN-1:0] gp,
  input wire logic run,
  input wire logic side,
  input wire logic pos,
  input wire logic neg,
  output logic [spm_pkg::NPIN-1:0] pin_i
  );
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  logic lclk = 1'b0;
  logic rp = 1'b0;
  logic rn = 1'b0;
  logic [NPIN-1:0] lvl;
  // port clock stands still low outside a frame
  always #62.5 lclk = run ? ~lclk : 1'b0;
  // rails change on the rising edge so they sit still around the fall
  always @(posedge lclk)
  begin
    rp <= pos;
    rn <= neg;
  end
  always_comb
  begin
    lvl = gp;
    if (run)
    begin
      lvl[CLK_PIN[side]] = lclk;
      lvl[POS_PIN[side]] = rp;
      lvl[NEG_PIN[side]] = rn;
    end
    pin_i = (pin_oe & pin_o) | (~pin_oe & lvl);
  end
endmodule : spm_link_far

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq;
  logic run = 1'b0, side = 1'b0, pos = 1'b0, neg = 1'b0;
  logic [1:0] xp = 2'b00, xn = 2'b00;
  logic [1:0] ins_p, ins_n, ins_v, take;
  logic [7:0] gp = 8'h00;
  logic [7:0] pin_i, pin_o, pin_oe, chan_loss;
  logic [3:0] ing_sel, egr_sel;
  int num_errors = 0;
  int checked = 0;

  always #2.5 clk = ~clk;

  spm_pin_mux #(.HALF_CYC(2)) u_spm_pin_mux (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .chan_loss(chan_loss), .ing_sel(ing_sel), .ing_ins_pos(ins_p[0]),
    .ing_ins_neg(ins_n[0]), .ing_ins_vld(ins_v[0]),
    .ing_ext_pos(xp[0]), .ing_ext_neg(xn[0]), .ing_ext_take(take[0]),
    .egr_sel(egr_sel), .egr_ins_pos(ins_p[1]), .egr_ins_neg(ins_n[1]),
    .egr_ins_vld(ins_v[1]), .egr_ext_pos(xp[1]), .egr_ext_neg(xn[1]),
    .egr_ext_take(take[1]), .irq(irq));

  spm_link_far u_spm_link_far (
    .pin_o(pin_o), .pin_oe(pin_oe), .gp(gp), .run(run), .side(side),
    .pos(pos), .neg(neg), .pin_i(pin_i));

  task automatic conclude;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // hready is sampled at the edge, so the slave may stretch either phase
  task automatic bus(input logic wr_en, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  initial
  begin
    #100us;
    num_errors++;
    conclude();
  end

  initial
  begin
    logic [31:0] c;
    logic b;
    logic tk;
    int n;
    tick(3);
    chk(pin_oe, 8'h00);
    rst_b <= 1'b1;
    rd(ADDR_DIR, 32'h0);
    rd(ADDR_LEVEL, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_MASK, 32'h0);
    wr(12'h004, 32'hffffffff);
    rd(12'h004, 32'h0);
    chk(hresp, 1'b0);
    gp <= 8'hc0;
    wr(ADDR_DIR, 32'h0f);
    wr(ADDR_LEVEL, 32'ha5);
    tick(6);
    chk(pin_oe, 8'h0f);
    chk(pin_o & 8'h0f, 8'h05);
    chk(chan_loss, 8'h00);
    rd(ADDR_DIR, 32'h0f);
    rd(ADDR_LEVEL, 32'hc5);
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_MASK, 32'h040);
    wr(ADDR_CTRL, 32'h040);
    gp <= 8'h40;
    tick(8);
    chk(chan_loss, 8'h40);
    chk(irq, 1'b1);
    gp <= 8'h00;
    tick(8);
    chk(chan_loss, 8'h00);
    wr(ADDR_STS, 32'h040);
    tick(3);
    chk(irq, 1'b0);
    rd(ADDR_STS, 32'h0);
    wr(ADDR_MASK, 32'h300);
    for (int s = 0; s < 2; s++)
    begin
      c = 32'h0;
      c[CTL_ING_EN + 2 * s] = 1'b1;
      c[19:16] = 4'h9;
      c[23:20] = 4'h6;
      wr(ADDR_CTRL, c);
      side <= s[0];
      pos <= 1'b1;
      neg <= s[0];
      run <= 1'b1;
      n = 0;
      while (ins_v[s] !== 1'b1 && n < 400)
      begin
        tick(1);
        n++;
      end
      chk(ins_p[s], 1'b1);
      chk(ins_n[s], s[0]);
      chk(pin_oe, 8'h00);
      chk(s ? egr_sel : ing_sel, s ? 4'h6 : 4'h9);
      tick(3);
      chk(irq, 1'b1);
      run <= 1'b0;
      tick(40);
      wr(ADDR_STS, 32'h3ff);
      c[CTL_ING_EXT + 2 * s] = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
        xp[s] <= k[0];
        xn[s] <= !k[0];
        if (k == 0)
          wr(ADDR_CTRL, c);
        b = 1'b1;
        tk = 1'b0;
        n = 0;
        while (!(b === 1'b0 && pin_o[CLK_PIN[s]] === 1'b1) && n < 200)
        begin
          b = pin_o[CLK_PIN[s]];
          tk = take[s];
          tick(1);
          n++;
        end
        chk(tk, 1'b1);
        chk(pin_o[POS_PIN[s]], k[0]);
        chk(pin_o[NEG_PIN[s]], !k[0]);
        chk(pin_oe, s ? 8'h29 : 8'h16);
      end
      wr(ADDR_CTRL, 32'h0);
    end
    conclude();
  end
endmodule : tb
